// ---- core/display_host_port.sv ----
// Host-side controller for a display module control bus in three variants.
// Assumes one request at a time from the user side and a display module
// that follows the bus; read pins are synchronised before use.
// Operation
// RQ1 - Parallel variant A: static or clocked strobe
// RQ2 - Variant A write: command/data flag per word
// RQ3 - Static mode keeps timing strobe high
// RQ4 - Variant A read: command/data held low
// RQ5 - Clocked read: select low while data valid
// RQ6 - Variant B write: pulse write strobe low
// RQ7 - Command low, data high on flag line
// RQ8 - Variant B read: pulse read strobe, sample rise
// RQ9 - Variant B read: command/data held high
// RQ10 - Module tristates read data when flag low
// RQ11 - Module tolerates asynchronous stopped strobes
// RQ12 - Serial write: one bit per clock pulse
// RQ13 - Select falling starts serial sequence, rising ends
// RQ14 - Serial byte is eight, nine or sixteen
// RQ15 - Serial read: host samples on rising clock
// RQ16 - Serial read byte is eight cycles
// RQ17 - Serial read still drives flag line
// RQ18 - Serial bytes go most significant first
// RQ19 - Mid-byte deselect restarts byte at module
// RQ20 - Between-byte deselect pauses the sequence
// RQ21 - Module may return frame sync output
// RQ22 - Module ignores bus while deselected
// RQ23 - Reset line low resets the module
// RQ24 - Static mode: write at select fall
// RQ25 - Clocked mode: write at strobe fall
// RQ26 - Module synchronises strobes before edge detect
`timescale 1ns/1ps
module display_host_port #(
  parameter int DATA_W = 16
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire host_port_pkg::mode_t     bus_mode,
  input  wire host_port_pkg::ser_fmt_t  ser_fmt,
  input  wire logic                     ser_shared,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire logic                     req_is_read,
  input  wire logic                     req_is_data,
  input  wire logic [DATA_W-1:0]        req_word,
  output logic                          resp_valid,
  output logic [DATA_W-1:0]             resp_word,
  input  wire logic                     dev_reset_req,
  output logic                          frame_sync_pulse,
  output logic                          frame_sync_level,
  output logic                          module_select_n,
  output logic                          cmd_data_sel,
  output logic                          read_write_n,
  output logic                          timing_strobe,
  output logic                          read_strobe_n,
  output logic                          write_strobe_n,
  output logic                          module_reset_n,
  output logic [DATA_W-1:0]             dq_o,
  output logic                          dq_oe,
  input  wire logic [DATA_W-1:0]        dq_i,
  output logic                          ser_clk,
  output logic                          ser_out,
  input  wire logic                     ser_in,
  output logic                          sda_o,
  output logic                          sda_oe,
  input  wire logic                     sda_i,
  input  wire logic                     frame_sync_out
);
  import host_port_pkg::*;

  // Sequencer and timer
  state_t              state_reg, state_next;
  logic [TMR_W-1:0]    tmr_reg, tmr_next;
  logic [CNT_W-1:0]    bits_reg, bits_next;
  // Latched request
  mode_t               mode_reg;
  ser_fmt_t            fmt_reg;
  logic                shared_reg;
  logic                is_read_reg;
  logic                is_data_reg;
  logic [DATA_W-1:0]   wr_word_reg;
  logic [SER_W-1:0]    shift_reg, shift_next;
  logic [DATA_W-1:0]   rd_word_reg, rd_word_next;
  // Registered pins
  logic                sel_n_reg, dc_reg, rw_reg, e_reg;
  logic                rd_n_reg, wr_n_reg, rst_n_reg;
  logic                dq_oe_reg, scl_reg, sda_oe_reg;
  logic                resp_valid_reg, te_prev_reg, te_pulse_reg;
  // Synchronised pin inputs
  logic [SYNC_W-1:0]   pins_s;

  // Frame bits for a serial byte, flag bit leading in the nine and sixteen bit formats
  function automatic logic [SER_W-1:0] build_frame(
    input ser_fmt_t          fmt,
    input logic              flag,
    input logic [BYTE_W-1:0] byte_v
  );
    logic [SER_W-1:0] f;
    f = '0;
    unique case (fmt)
      SER_8_DC: f = {byte_v, 8'h00};
      SER_9:    f = {flag, byte_v, 7'h00};
      SER_16:   f = {flag, 7'h00, byte_v};
    endcase
    return f;
  endfunction : build_frame

  // Bits in one serial byte
  function automatic logic [CNT_W-1:0] frame_bits(
    input ser_fmt_t fmt,
    input logic     rd
  );
    logic [CNT_W-1:0] n;
    n = CNT_W'(BITS_DC);
    // RQ16 reads always eight bits
    if (rd) begin
      n = CNT_W'(RD_BITS);
    end else begin
      unique case (fmt)
        SER_8_DC: n = CNT_W'(BITS_DC);
        SER_9:    n = CNT_W'(BITS_9);
        SER_16:   n = CNT_W'(BITS_16);
      endcase
    end
    return n;
  endfunction : frame_bits

  // Read pins pass two flops before any logic sees them
  pin_sync #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({ser_in, sda_i, frame_sync_out, dq_i}),
    .sync_out (pins_s)
  );

  // Handshake and state decode
  wire accept    = (state_reg == ST_IDLE) && req_valid;
  wire tmr_done  = (tmr_reg == '0);
  // Request as the pins see it; fresh fields on the accept edge
  // so no pin shows a stale mode for one cycle
  mode_t mode_cur;
  assign mode_cur = accept ? bus_mode : mode_reg;
  wire rd_cur    = accept ? req_is_read : is_read_reg;
  wire dc_cur    = accept ? req_is_data : is_data_reg;
  wire sh_cur    = accept ? ser_shared : shared_reg;
  wire is_serial = (mode_cur == MODE_C);
  wire more_bits = (bits_reg > CNT_W'(1));
  wire sample    = (state_reg == ST_P1) && tmr_done && is_read_reg;
  wire ser_bit   = shared_reg ? pins_s[SYNC_SDA_BIT] : pins_s[SYNC_DIN_BIT];
  wire n_active  = (state_next == ST_SETUP) || (state_next == ST_P1) ||
                   (state_next == ST_P2);
  wire n_p1      = (state_next == ST_P1);
  wire n_p2      = (state_next == ST_P2);
  wire n_mode_a  = (mode_cur == MODE_A_FIXED) || (mode_cur == MODE_A_CLOCKED);

  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_done ? tmr_reg : tmr_reg - TMR_W'(1);
    bits_next  = bits_reg;
    shift_next = shift_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          state_next = ST_SETUP;
          tmr_next   = TMR_W'(SETUP_CYC - 1);
          bits_next  = (bus_mode == MODE_C) ?
                       frame_bits(ser_fmt, req_is_read) : CNT_W'(1);
          // RQ18 most significant first
          shift_next = build_frame(ser_fmt, req_is_data,
                                   req_word[BYTE_W-1:0]);
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          state_next = ST_P1;
          tmr_next   = TMR_W'(HALF_CYC - 1);
        end
      end
      ST_P1: begin
        if (tmr_done) begin
          state_next = ST_P2;
          tmr_next   = TMR_W'(HALF_CYC - 1);
        end
      end
      ST_P2: begin
        if (tmr_done) begin
          tmr_next = TMR_W'(HALF_CYC - 1);
          // RQ14 loop over the byte's bits
          if (is_serial && more_bits) begin
            state_next = ST_P1;
            bits_next  = bits_reg - CNT_W'(1);
            shift_next = {shift_reg[SER_W-2:0], 1'b0};
          end else begin
            state_next = ST_END;
          end
        end
      end
      ST_END: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // Read capture: parallel word or serial bit shifted in
  // RQ8 sample at end of low phase
  assign rd_word_next = is_serial ?
                        {rd_word_reg[DATA_W-2:0], ser_bit} :
                        pins_s[DATA_W-1:0];

  // Next pin levels, registered below
  // RQ13 select spans the whole serial byte
  // RQ24 static mode: select low is the strobe
  // RQ5 clocked read: select spans valid data
  wire sel_n_next = (mode_cur == MODE_A_FIXED) ? !n_p1 : !n_active;
  // RQ3 timing strobe held high in static mode
  // RQ25 clocked write falls after high phase; read rises after low
  wire e_next = (mode_cur == MODE_A_FIXED) ? 1'b1 :
                (mode_cur != MODE_A_CLOCKED) ? E_IDLE :
                rd_cur ? n_p2 : n_p1;
  // RQ6 write strobe low then rising
  wire wr_n_next = !((mode_cur == MODE_B) && !rd_cur && n_p1);
  // RQ8 read strobe low then rising
  wire rd_n_next = !((mode_cur == MODE_B) && rd_cur && n_p1);
  // RQ12 serial clock low then rising per bit
  wire scl_next = !(is_serial && n_p1);
  // RQ4 RQ9 flag level fixed during reads
  // RQ2 RQ7 RQ17 flag follows request elsewhere
  wire dc_val = (n_mode_a && rd_cur) ? 1'b0 :
                ((mode_cur == MODE_B) && rd_cur) ? 1'b1 : dc_cur;
  wire dc_next  = n_active ? dc_val : dc_reg;
  wire rw_next  = n_active ? (n_mode_a && rd_cur) : rw_reg;
  // RQ1 host drives the bus only on parallel writes
  wire dq_oe_next  = n_active && !is_serial && !rd_cur;
  // RQ15 shared serial line released on reads
  wire sda_oe_next = n_active && is_serial && sh_cur && !rd_cur;

  // Sequencer registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      tmr_reg   <= '0;
      bits_reg  <= '0;
      shift_reg <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
      bits_reg  <= bits_next;
      shift_reg <= shift_next;
    end
  end

  // Request latch, taken on accept
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_reg    <= MODE_A_FIXED;
      fmt_reg     <= SER_8_DC;
      shared_reg  <= 1'b0;
      is_read_reg <= 1'b0;
      is_data_reg <= 1'b0;
      wr_word_reg <= '0;
    end else if (accept) begin
      mode_reg    <= bus_mode;
      fmt_reg     <= ser_fmt;
      shared_reg  <= ser_shared;
      is_read_reg <= req_is_read;
      is_data_reg <= req_is_data;
      wr_word_reg <= req_word;
    end
  end

  // Read data, cleared on accept so serial bytes start clean
  always_ff @(posedge core_clk) begin
    if (!rst_b || accept) begin
      rd_word_reg <= '0;
    end else if (sample) begin
      rd_word_reg <= rd_word_next;
    end
  end

  // Pin registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sel_n_reg  <= SEL_IDLE;
      dc_reg     <= 1'b0;
      rw_reg     <= 1'b0;
      e_reg      <= E_IDLE;
      rd_n_reg   <= STROBE_IDLE;
      wr_n_reg   <= STROBE_IDLE;
      scl_reg    <= STROBE_IDLE;
      dq_oe_reg  <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      sel_n_reg  <= sel_n_next;
      dc_reg     <= dc_next;
      rw_reg     <= rw_next;
      e_reg      <= e_next;
      rd_n_reg   <= rd_n_next;
      wr_n_reg   <= wr_n_next;
      scl_reg    <= scl_next;
      dq_oe_reg  <= dq_oe_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // Module reset, response strobe and frame sync edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rst_n_reg      <= 1'b0;
      resp_valid_reg <= 1'b0;
      te_prev_reg    <= 1'b0;
      te_pulse_reg   <= 1'b0;
    end else begin
      // RQ23 reset line held low on request
      rst_n_reg      <= !dev_reset_req;
      resp_valid_reg <= (state_reg == ST_END) && tmr_done && is_read_reg;
      te_prev_reg    <= pins_s[SYNC_TE_BIT];
      // RQ21 rising frame sync becomes a pulse
      te_pulse_reg   <= pins_s[SYNC_TE_BIT] && !te_prev_reg;
    end
  end

  // Outputs
  assign req_ready        = (state_reg == ST_IDLE);
  assign resp_valid       = resp_valid_reg;
  assign resp_word        = rd_word_reg;
  assign frame_sync_pulse = te_pulse_reg;
  assign frame_sync_level = te_prev_reg;
  assign module_select_n  = sel_n_reg;
  assign cmd_data_sel     = dc_reg;
  assign read_write_n     = rw_reg;
  assign timing_strobe    = e_reg;
  assign read_strobe_n    = rd_n_reg;
  assign write_strobe_n   = wr_n_reg;
  assign module_reset_n   = rst_n_reg;
  assign dq_o             = wr_word_reg;
  assign dq_oe            = dq_oe_reg;
  assign ser_clk          = scl_reg;
  assign ser_out          = shift_reg[SER_W-1];
  assign sda_o            = shift_reg[SER_W-1];
  assign sda_oe           = sda_oe_reg;

  // Checks on the driven pins
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_fixed_e_high;
    (mode_reg == MODE_A_FIXED && state_reg != ST_IDLE) |-> ##1 timing_strobe;
  endproperty
  a_fixed_e_high: assert property (p_fixed_e_high) // RQ3
    else $error("timing strobe not high in static mode");

  property p_a_read_dc_low;
    (n_mode_a && rw_reg && !sel_n_reg) |-> !cmd_data_sel;
  endproperty
  a_a_read_dc_low: assert property (p_a_read_dc_low) // RQ4
    else $error("command/data not low in variant A read");

  property p_b_read_dc_high;
    !read_strobe_n |-> cmd_data_sel && !dq_oe;
  endproperty
  a_b_read_dc_high: assert property (p_b_read_dc_high) // RQ9
    else $error("command/data not high in variant B read");

  property p_wr_data_held;
    $rose(write_strobe_n) |-> dq_oe && $stable(dq_o) ##1 dq_oe;
  endproperty
  a_wr_data_held: assert property (p_wr_data_held) // RQ6
    else $error("bus not driven across write strobe rise");

  property p_rd_pulse_len;
    $fell(read_strobe_n) |-> (!read_strobe_n)[*8] ##1 read_strobe_n;
  endproperty
  a_rd_pulse_len: assert property (p_rd_pulse_len) // RQ8
    else $error("read strobe low phase not eight cycles");

  property p_scl_in_frame;
    $fell(ser_clk) |-> (!module_select_n && !ser_clk)[*8] ##1
      (!module_select_n && ser_clk);
  endproperty
  a_scl_in_frame: assert property (p_scl_in_frame) // RQ13
    else $error("serial clock pulsed outside select");

  property p_ser_bit_stable;
    $rose(ser_clk) |-> $stable(ser_out) && !module_select_n;
  endproperty
  a_ser_bit_stable: assert property (p_ser_bit_stable) // RQ12
    else $error("serial bit changed at rising clock");

  property p_ser_read_release;
    (is_serial && is_read_reg && state_reg != ST_IDLE) |-> ##1 !sda_oe;
  endproperty
  a_ser_read_release: assert property (p_ser_read_release) // RQ15
    else $error("host drives shared line during serial read");

  property p_e_write_fall;
    ($fell(timing_strobe) && !read_write_n && !$past(module_select_n)) |->
      dq_oe && !module_select_n && $past(dq_oe);
  endproperty
  a_e_write_fall: assert property (p_e_write_fall) // RQ25
    else $error("clocked write strobe fell without data");

  property p_fixed_sel_fall;
    ($fell(module_select_n) && mode_reg == MODE_A_FIXED && !rw_reg) |->
      dq_oe && $past(dq_oe);
  endproperty
  a_fixed_sel_fall: assert property (p_fixed_sel_fall) // RQ24
    else $error("static write select fell without data");

  c_serial_write: cover property ($rose(ser_clk) && sda_oe);
  c_b_read: cover property ($rose(read_strobe_n) ##[1:40] resp_valid);
  c_fixed_write: cover property ($fell(module_select_n) && timing_strobe);
  c_clocked_read: cover property ($rose(timing_strobe) && read_write_n);

endmodule : display_host_port

// ---- core/host_port_pkg.sv ----
// Shared constants and types for the display control-bus host port.
// Assumes a single 125 MHz core clock; every pin timing is counted in it.
package host_port_pkg;

  // Clock and bus timing, in nanoseconds as specified
  localparam int CLK_PERIOD_NS = 8;    // Core clock period
  localparam int T_UNIT_NS     = 10;   // Bus time unit T
  localparam int STROBE_NS     = 6 * T_UNIT_NS;  // Each strobe phase
  localparam int SETUP_NS      = 4 * T_UNIT_NS;  // Select/address setup

  // Least times round up to whole cycles
  localparam int HALF_CYC  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W     = 4;        // Phase timer width

  // Widths and bit counts
  localparam int DATA_W      = 16;     // Parallel information bus
  localparam int SER_W       = 16;     // Serial frame shift register
  localparam int CNT_W       = 5;      // Serial bit counter
  localparam int BYTE_W      = 8;      // Serial byte
  localparam int RD_BITS     = 8;      // Bits in a serial read byte
  localparam int BITS_DC     = 8;      // Serial byte with command line
  localparam int BITS_9      = 9;      // Serial byte, flag bit leading
  localparam int BITS_16     = 16;     // Serial byte, flag plus padding
  localparam int PAD_16_W    = 7;      // Padding after flag, 16-bit frame

  // Field positions inside the synchroniser vector
  localparam int SYNC_TE_BIT  = DATA_W;
  localparam int SYNC_SDA_BIT = DATA_W + 1;
  localparam int SYNC_DIN_BIT = DATA_W + 2;
  localparam int SYNC_W       = DATA_W + 3;

  // Pin reset values
  localparam logic SEL_IDLE    = 1'b1;  // Module deselected
  localparam logic STROBE_IDLE = 1'b1;  // Read/write/serial strobes high
  localparam logic E_IDLE      = 1'b0;  // Clocked timing strobe low

  // Bus variant
  typedef enum logic [1:0] {
    MODE_A_FIXED,    // Parallel, static timing strobe
    MODE_A_CLOCKED,  // Parallel, clocked timing strobe
    MODE_B,          // Parallel, separate read/write strobes
    MODE_C           // Serial
  } mode_t;

  // Serial byte framing
  typedef enum logic [1:0] {
    SER_8_DC,        // Eight cycles, command/data line used
    SER_9,           // Nine cycles, flag bit first
    SER_16           // Sixteen cycles, flag bit first then padding
  } ser_fmt_t;

  // Transfer sequencer
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_P1, ST_P2, ST_END
  } state_t;

endpackage : host_port_pkg

// ---- core/pin_sync.sv ----
// Two-stage synchroniser for pins arriving from the display module.
// Assumes inputs are asynchronous to core_clk; only stage two is read.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;   // First stage, feeds stage two only
  logic [WIDTH-1:0] stable_reg; // Second stage

  // Two flops per bit, cleared by reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      meta_reg   <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule : pin_sync

// ---- tb/display_module_model.sv ----
// Behavioural display module on the far side of the host port pins.
// Assumes the bench names the fitted bus variant and the word to return.
`timescale 1ns/1ps
module display_module_model (
  input  wire host_port_pkg::mode_t variant,     // Fitted bus variant
  input  wire logic [15:0]          rd_val,      // Word given on reads
  input  wire logic                 te_in,       // Sync level to send
  input  wire logic                 module_select_n,
  input  wire logic                 cmd_data_sel,
  input  wire logic                 read_write_n,
  input  wire logic                 timing_strobe,
  input  wire logic                 read_strobe_n,
  input  wire logic                 write_strobe_n,
  input  wire logic                 module_reset_n,
  input  wire logic [15:0]          dq_o,
  input  wire logic                 dq_oe,
  output logic      [15:0]          dq_i,
  input  wire logic                 ser_clk,
  input  wire logic                 ser_out,
  output logic                      ser_in,
  input  wire logic                 sda_o,
  input  wire logic                 sda_oe,
  output logic                      sda_i,
  output logic                      frame_sync_out,
  output logic      [15:0]          wr_word,     // Last word taken
  output logic      [15:0]          sh,          // Serial bits taken
  output logic      [4:0]           bcnt,        // Bits in this byte
  output logic                      last_dc,     // Flag at last transfer
  output logic                      last_e       // E at last transfer
);
  import host_port_pkg::*;
  logic       sel;   // Module selected
  logic       a_rd;  // Variant A read under way
  logic       b_rd;  // Variant B read pulse
  logic       s_en;  // Serial read bit driven
  logic       s_bit; // Serial read bit
  logic [3:0] rcnt;  // Serial read bits sent

  assign sel  = !module_select_n;
  assign a_rd = sel && read_write_n &&
                (variant == MODE_A_FIXED || variant == MODE_A_CLOCKED);
  assign b_rd = sel && variant == MODE_B && !read_strobe_n && cmd_data_sel;
  // Released lines show the inverse, no pull on them
  assign dq_i   = dq_oe ? dq_o : (a_rd || b_rd) ? rd_val : ~rd_val;
  assign ser_in = s_en ? s_bit : ~s_bit;
  assign sda_i  = sda_oe ? sda_o : ser_in;
  assign frame_sync_out = te_in;

  // Record flag and E, optionally the word
  task automatic note(input logic take);
    if (take) wr_word = dq_i;
    last_dc = cmd_data_sel;
    last_e  = timing_strobe;
  endtask : note

  always @(module_reset_n) begin
    if (!module_reset_n) begin
      wr_word = '0;
      sh      = '0;
      bcnt    = '0;
      rcnt    = '0;
      s_en    = 1'b0;
      s_bit   = 1'b0;
    end
  end
  always @(negedge module_select_n) begin
    bcnt = '0;
    rcnt = '0;
    if (variant == MODE_A_FIXED && !read_write_n) note(1'b1);
  end
  always @(posedge module_select_n) begin
    if (variant == MODE_A_FIXED && read_write_n) note(1'b0);
  end
  // write at E fall, read at E rise
  always @(timing_strobe) begin
    if (sel && variant == MODE_A_CLOCKED && timing_strobe == read_write_n)
      note(!read_write_n);
  end
  always @(posedge write_strobe_n) if (sel && variant == MODE_B) note(1'b1);
  always @(posedge read_strobe_n) if (sel && variant == MODE_B) note(1'b0);
  // edge driven, take bit, then release
  always @(posedge ser_clk) begin
    if (sel && variant == MODE_C) begin
      sh      = {sh[14:0], sda_oe ? sda_o : ser_out};
      bcnt    = bcnt + 5'h01;
      last_dc = cmd_data_sel;
    end
    #20 s_en = 1'b0;
  end
  // next read bit after fall, high bit first
  always @(negedge ser_clk) begin
    if (sel && variant == MODE_C && !sda_oe && rcnt < 4'h8) begin
      s_bit = rd_val[3'h7 - rcnt[2:0]];
      rcnt  = rcnt + 4'h1;
      s_en  = 1'b1;
    end
  end
endmodule : display_module_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the display host port against a module model.
// Assumes the port package and one 8 ns core clock.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb_top;
  import host_port_pkg::*;
  logic        core_clk, rst_b, ser_shared, req_valid, req_ready;
  logic        req_is_read, req_is_data, resp_valid, dev_reset_req;
  logic        frame_sync_pulse, frame_sync_level, module_select_n;
  logic        cmd_data_sel, read_write_n, timing_strobe, read_strobe_n;
  logic        write_strobe_n, module_reset_n, dq_oe, ser_clk, ser_out;
  logic        ser_in, sda_o, sda_oe, sda_i, frame_sync_out, te;
  logic        last_dc, last_e;
  logic [15:0] req_word, resp_word, dq_o, dq_i, rd_val, wr_word, sh, lfsr_q;
  logic [4:0]  bcnt;
  mode_t       bus_mode;
  ser_fmt_t    ser_fmt;
  int          error_cnt = 0, total_checks = 0, pulse_cnt = 0, rise_cnt = 0;

  // Core clock
  always #4 core_clk = ~core_clk;

  display_host_port dut (.core_clk, .rst_b, .bus_mode, .ser_fmt, .ser_shared,
    .req_valid, .req_ready, .req_is_read, .req_is_data, .req_word,
    .resp_valid, .resp_word, .dev_reset_req, .frame_sync_pulse,
    .frame_sync_level, .module_select_n, .cmd_data_sel, .read_write_n,
    .timing_strobe, .read_strobe_n, .write_strobe_n, .module_reset_n, .dq_o,
    .dq_oe, .dq_i, .ser_clk, .ser_out, .ser_in, .sda_o, .sda_oe, .sda_i,
    .frame_sync_out);

  display_module_model model (.variant(bus_mode), .rd_val, .te_in(te),
    .module_select_n, .cmd_data_sel, .read_write_n, .timing_strobe,
    .read_strobe_n, .write_strobe_n, .module_reset_n, .dq_o, .dq_oe, .dq_i,
    .ser_clk, .ser_out, .ser_in, .sda_o, .sda_oe, .sda_i, .frame_sync_out,
    .wr_word, .sh, .bcnt, .last_dc, .last_e);

  // Count sync pulses from the port
  always @(posedge core_clk) if (frame_sync_pulse === 1'b1) pulse_cnt++;

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step
  // Bits in one serial write byte
  function automatic int exp_bits(input ser_fmt_t f);
    return f == SER_8_DC ? 8 : f == SER_9 ? 9 : 16;
  endfunction : exp_bits
  // Cycles from accept to ready or answer
  function automatic int exp_lat(input mode_t m, ser_fmt_t f, logic rd);
    int nb;
    nb = (m != MODE_C) ? 1 : rd ? RD_BITS : exp_bits(f);
    return SETUP_CYC + HALF_CYC * (2 * nb + 1);
  endfunction : exp_lat
  // Serial frame as it should arrive
  function automatic logic [15:0] exp_ser(input ser_fmt_t f, logic dc,
                                          logic [7:0] b);
    if (f == SER_8_DC) return {8'h00, b};
    return f == SER_9 ? {7'h00, dc, b} : {dc, 7'h00, b};
  endfunction : exp_ser

  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // One request, wait for its end, then compare
  task automatic run(input mode_t m, ser_fmt_t f, logic rd, logic [15:0] w);
    int          n;
    logic        dc;
    logic [15:0] mask;
    n = 0;
    mask = 16'hffff >> (16 - exp_bits(f));
    @(negedge core_clk);
    lfsr_q = lfsr_step(lfsr_q);
    dc = lfsr_q[1];
    if (!te && lfsr_q[0]) rise_cnt++;
    te = lfsr_q[0];
    rd_val = lfsr_q ^ 16'h5a5a;
    bus_mode = m;
    ser_fmt = f;
    ser_shared = lfsr_q[2];
    req_is_read = rd;
    req_is_data = dc;
    req_word = w;
    req_valid = 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    req_valid = 1'b0;
    while (n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
      if (rd ? resp_valid === 1'b1 : req_ready === 1'b1) break;
    end
    if (n >= 400) begin
      error_cnt++;
      end_sim();
    end
    `CHK(n, exp_lat(m, f, rd));
    `CHK(frame_sync_level, te);
    if (m == MODE_A_FIXED) `CHK(last_e, 1'b1);
    if (rd && m == MODE_C) `CHK(resp_word, {8'h00, rd_val[7:0]});
    if (rd && m != MODE_C) `CHK(resp_word, rd_val);
    if (rd && m == MODE_A_CLOCKED) `CHK(resp_word, rd_val);
    if (rd && m == MODE_C) `CHK(bcnt, RD_BITS);
    if (rd && m < MODE_B) `CHK(last_dc, 1'b0);
    if (rd && m == MODE_B) `CHK(last_dc, 1'b1);
    if (m == MODE_C && f == SER_8_DC) `CHK(last_dc, dc);
    if (!rd && m != MODE_C) `CHK(wr_word, w);
    if (!rd && m != MODE_C) `CHK(last_dc, dc);
    if (!rd && m == MODE_C) `CHK(sh & mask, exp_ser(f, dc, w[7:0]));
    if (!rd && m == MODE_C) `CHK(bcnt, exp_bits(f));
  endtask : run

  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {ser_shared, req_valid, req_is_read, req_is_data, dev_reset_req} = '0;
    {req_word, rd_val} = '0;
    te = 1'b0;
    bus_mode = MODE_A_FIXED;
    ser_fmt = SER_8_DC;
    lfsr_q = 16'h002c;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    #1;
    `CHK(module_reset_n, 1'b0);
    @(posedge core_clk);
    #1;
    `CHK(module_reset_n, 1'b1);
    // Every variant, format and direction with edge words
    for (int k = 0; k < 24; k++) begin
      run(mode_t'(k / 6), ser_fmt_t'((k % 6) / 2), k[0],
          k[1] ? 16'hffff : 16'h8001);
    end
    // Random traffic
    for (int k = 0; k < 40; k++) begin
      lfsr_q = lfsr_step(lfsr_q);
      run(mode_t'(lfsr_q[1:0]), ser_fmt_t'(lfsr_q[3:2] % 3), lfsr_q[4],
          lfsr_q ^ 16'h3c3c);
    end
    @(negedge core_clk);
    dev_reset_req = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(module_reset_n, 1'b0);
    @(negedge core_clk);
    dev_reset_req = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    `CHK(module_reset_n, 1'b1);
    `CHK(pulse_cnt, rise_cnt);
    end_sim();
  end
endmodule : tb_top
